/* File: gpio_pin_config_lock.sv */
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// - Direction zero makes an input; config 00 analog, 01 floating, 10 pulled.
// - Non-zero direction makes an output; config then picks the output type.
// - Pulled input applies pull-up when the output data bit is 1.
// - Pulled input applies pull-down when the output data bit is 0.
// - Output with config 00 is general push-pull.
// - Output with config 01 is general open-drain.
// - Output with config 10 is alternate push-pull.
// - Output with config 11 is alternate open-drain.
// - Open-drain pull control acts only in open-drain output modes.
// - A 4-bit alternate select per pin picks the driving peripheral.
// - During and after reset every pin except the two debug pins is a floating input.
// - Debug clock pin resets pulled down, debug data pin pulled up.
// - General output drives each pin from its output data bit.
// - Pins are sampled into input data every clock; reads return it.
// - Inputs have the driver off; floating and pulled inputs have the input path on.
// - Outputs enable the driver except open-drain at 1; push-pull outputs have no pulls.
// - Open-drain drives low for 0 and floats for 1.
// - Push-pull drives low for 0 and high for 1.
// - Output data reads return the last written value.
// - Alternate output drives the pin from the selected peripheral.
// - Bidirectional alternate keeps the input path floating unless an open-drain pull is enabled.
// - After lock the key bit reads 1 and lock writes are ignored.
// - Each lock bit freezes its pin's four configuration bits.
// - Unlocked pins and registers other than the lock register stay writable after lock.
module gpio_pin_config_lock
  import gpio_pkg::*;
#(
  parameter int PINS = 16,
  parameter int ALT_FUNCS = 16
)
(
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Register port.
  input  wire gpio_pkg::reg_req_t        req,
  output logic [31:0]                    rdata,
  // Pads.
  input  wire logic [PINS-1:0]           pad_in,
  output logic [PINS-1:0]                pad_out,
  output logic [PINS-1:0]                pad_oe,
  output logic [PINS-1:0]                pad_pull_en,
  output logic [PINS-1:0]                pad_pull_up,
  output logic [PINS-1:0]                pad_in_en,
  // Peripheral signals.
  input  wire logic [ALT_FUNCS*PINS-1:0] periph_out,
  output logic [PINS-1:0]                periph_in
);

  typedef struct packed {
    logic [31:0]     cfg_lo;
    logic [31:0]     cfg_hi;
    logic [15:0]     odata;
    logic [15:0]     idata;
    logic [31:0]     pull;
    logic [31:0]     alt_lo;
    logic [31:0]     alt_hi;
    logic [31:0]     rdata;
    logic [15:0]     out;
    logic [15:0]     oe;
    logic [15:0]     pen;
    logic [15:0]     pup;
    logic [15:0]     ien;
    logic [15:0]     pin;
  } top_regs_t;

  top_regs_t s_reg;
  top_regs_t s_next;

  logic             locked;
  logic [15:0]      lock_mask;
  pad_ctrl_t [15:0] pads;
  logic [15:0]      alt_drive;

  // Merge a written word into a config word, keeping locked nibbles.
  function automatic logic [31:0] merge_cfg(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [7:0]  frz);
    logic [31:0] r;
    r = wd;
    for (int i = 0; i < 8; i++)
      if (frz[i])
        r[i*4 +: 4] = old[i*4 +: 4];
    return r;
  endfunction

  // Lock key tracker.
  gpio_lock_seq u_lock (
    .clk    (clk),
    .rstn   (rstn),
    .wr     (req.wr && req.addr == OFF_CONFIG_LOCK),
    .wdata  (req.wdata[16:0]),
    .locked (locked),
    .mask   (lock_mask)
  );

  // Per-pin mode decoders and alternate function selection.
  for (genvar p = 0; p < 16; p++)
  begin : g_pin
    logic [3:0] sel;
    logic [3:0] nib;
    assign sel = (p < 8) ? s_reg.alt_lo[(p%8)*4 +: 4] : s_reg.alt_hi[(p%8)*4 +: 4];
    assign nib = (p < 8) ? s_reg.cfg_lo[(p%8)*4 +: 4] : s_reg.cfg_hi[(p%8)*4 +: 4];
    assign alt_drive[p] = periph_out[p*ALT_FUNCS + int'(sel)];
    gpio_pin_mode u_mode (
      .nibble  (nib),
      .out_bit (s_reg.odata[p]),
      .alt_out (alt_drive[p]),
      .pull_en (s_reg.pull[p]),
      .pull_up (s_reg.pull[PULL_SEL_LSB + p]),
      .pad     (pads[p])
    );
  end

  // Register writes, reads and registered pad controls.
  always_comb
  begin
    s_next = s_reg;
    s_next.idata = pad_in[15:0];
    s_next.rdata = 32'h0000_0000;
    if (req.wr)
    begin
      unique case (req.addr)
        OFF_CONFIG_LOW:  s_next.cfg_lo = merge_cfg(s_reg.cfg_lo, req.wdata, lock_mask[7:0]);
        OFF_CONFIG_HIGH: s_next.cfg_hi = merge_cfg(s_reg.cfg_hi, req.wdata, lock_mask[15:8]);
        OFF_OUTPUT_DATA: s_next.odata  = req.wdata[15:0];
        OFF_OD_PULL:     s_next.pull   = req.wdata;
        OFF_ALT_LOW:     s_next.alt_lo = req.wdata;
        OFF_ALT_HIGH:    s_next.alt_hi = req.wdata;
        default:         s_next.odata  = s_reg.odata;
      endcase
    end
    if (req.rd)
    begin
      unique case (req.addr)
        OFF_CONFIG_LOW:  s_next.rdata = s_reg.cfg_lo;
        OFF_CONFIG_HIGH: s_next.rdata = s_reg.cfg_hi;
        OFF_INPUT_DATA:  s_next.rdata = {16'h0000, s_reg.idata};
        OFF_OUTPUT_DATA: s_next.rdata = {16'h0000, s_reg.odata};
        OFF_CONFIG_LOCK: s_next.rdata = {15'h0000, locked, lock_mask};
        OFF_OD_PULL:     s_next.rdata = s_reg.pull;
        OFF_ALT_LOW:     s_next.rdata = s_reg.alt_lo;
        OFF_ALT_HIGH:    s_next.rdata = s_reg.alt_hi;
        default:         s_next.rdata = 32'h0000_0000;     // Unmapped reads return zero.
      endcase
    end
    for (int p = 0; p < 16; p++)
    begin
      s_next.out[p] = pads[p].out;
      s_next.oe[p]  = pads[p].oe;
      s_next.pen[p] = pads[p].pull_en;
      s_next.pup[p] = pads[p].pull_up;
      s_next.ien[p] = pads[p].in_en;
      s_next.pin[p] = pad_in[p] & pads[p].in_en;
    end
  end

  // Reset leaves all pins floating except the two debug pins, which pull.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_reg        <= '0;
      s_reg.cfg_lo <= CONFIG_RESET;
      s_reg.cfg_hi <= CONFIG_HIGH_RESET;
      s_reg.odata  <= OUTPUT_RESET;
      s_reg.ien    <= PAD_IN_EN_RESET;
      s_reg.pen    <= PULL_EN_RESET;
      s_reg.pup    <= PULL_UP_RESET;
    end
    else
      s_reg <= s_next;
  end

  // Outputs come straight from the state flip-flops.
  assign rdata       = s_reg.rdata;
  assign pad_out     = s_reg.out;
  assign pad_oe      = s_reg.oe;
  assign pad_pull_en = s_reg.pen;
  assign pad_pull_up = s_reg.pup;
  assign pad_in_en   = s_reg.ien;
  assign periph_in   = s_reg.pin;

  a_input_no_drive: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.cfg_lo[1:0] == 2'b00) |=> !pad_oe[0]) else $error("input pin driven");
  a_pull_follows: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.cfg_lo[3:0] == 4'h8) |=> pad_pull_en[0] && pad_pull_up[0] == $past(s_reg.odata[0]))
    else $error("pull mismatch");
  a_pp_drive: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.cfg_lo[3:0] == 4'h1) |=> pad_oe[0] && pad_out[0] == $past(s_reg.odata[0]) && !pad_pull_en[0])
    else $error("push-pull wrong");
  a_od_drive: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.cfg_lo[3:0] == 4'h5) |=> pad_oe[0] == !$past(s_reg.odata[0]))
    else $error("open-drain wrong");
  a_locked_nibble: assert property (@(posedge clk) disable iff (!rstn)
    lock_mask[0] |=> $stable(s_reg.cfg_lo[3:0])) else $error("locked nibble changed");
  a_idata_sample: assert property (@(posedge clk) disable iff (!rstn)
    rstn |=> s_reg.idata == $past(pad_in[15:0])) else $error("input not sampled");
  a_odata_read: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && req.addr == OFF_OUTPUT_DATA) |=> rdata[15:0] == $past(s_reg.odata))
    else $error("output data readback wrong");

  // Reset must leave no driver on and every digital input path open.
  a_reset_floating: assert property (@(posedge clk)
    !rstn |=> pad_oe == 16'h0000 && pad_in_en == PAD_IN_EN_RESET && pad_pull_en == PULL_EN_RESET)
    else $error("reset pad state wrong");
  // Alternate outputs follow the selected peripheral, not the output data bit.
  a_alt_drive: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.cfg_lo[3] && s_reg.cfg_lo[1:0] != 2'b00) |=> pad_out[0] == $past(alt_drive[0]))
    else $error("alternate output wrong");
  // Push-pull outputs never carry a weak pull, whatever the pull register holds.
  a_pp_no_pull: assert property (@(posedge clk) disable iff (!rstn)
    (!s_reg.cfg_lo[2] && s_reg.cfg_lo[1:0] != 2'b00) |=> !pad_pull_en[0])
    else $error("push-pull pull on");
  // Open-drain outputs take enable and direction from the pull register.
  a_od_pull: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.cfg_lo[2] && s_reg.cfg_lo[1:0] != 2'b00) |=>
    pad_pull_en[0] == $past(s_reg.pull[0]) && pad_pull_up[0] == $past(s_reg.pull[PULL_SEL_LSB]))
    else $error("open-drain pull wrong");
  // Once locked, the key bit reads back as one.
  a_lock_readback: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && req.addr == OFF_CONFIG_LOCK && locked) |=> rdata[16])
    else $error("lock bit not read back");
  // A pin outside the lock mask must still accept new configuration.
  a_unlocked_write: assert property (@(posedge clk) disable iff (!rstn)
    (req.wr && req.addr == OFF_CONFIG_LOW && !lock_mask[1]) |=>
    s_reg.cfg_lo[7:4] == $past(req.wdata[7:4]))
    else $error("unlocked nibble not written");

endmodule

/* File: gpio_pkg.sv */
package gpio_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [5:0] OFF_CONFIG_LOW  = 6'h00;
  localparam logic [5:0] OFF_CONFIG_HIGH = 6'h04;
  localparam logic [5:0] OFF_INPUT_DATA  = 6'h08;
  localparam logic [5:0] OFF_OUTPUT_DATA = 6'h0C;
  localparam logic [5:0] OFF_CONFIG_LOCK = 6'h18;
  localparam logic [5:0] OFF_OD_PULL     = 6'h1C;
  localparam logic [5:0] OFF_ALT_LOW     = 6'h20;
  localparam logic [5:0] OFF_ALT_HIGH    = 6'h24;

  // Pin count, lock key bit position and pull control field positions.
  localparam int NUM_PINS      = 16;
  localparam int LOCK_KEY_BIT  = 16;
  localparam int PULL_SEL_LSB  = 16;

  // Reset value of the low configuration word: every pin a floating input.
  localparam logic [31:0] CONFIG_RESET     = 32'h4444_4444;
  // Debug clock pin is pin 14 and debug data pin is pin 13 (high word).
  localparam int DEBUG_CLOCK_PIN = 14;
  localparam int DEBUG_DATA_PIN  = 13;
  // Input pull-up/pull-down code (config 10, direction 00) for the debug pins.
  localparam logic [3:0]  NIBBLE_PULL      = 4'h8;
  // Pins 13 and 14 take the pulled code; pins 8 to 12 and 15 stay floating inputs.
  localparam logic [31:0] CONFIG_HIGH_RESET = 32'h4884_4444;
  // Output data reset: debug data pin pulled up, debug clock pin pulled down.
  localparam logic [15:0] OUTPUT_RESET     = 16'h2000;
  // Registered pad controls after reset, matching the decoded reset configuration.
  localparam logic [15:0] PAD_IN_EN_RESET  = 16'hFFFF;
  localparam logic [15:0] PULL_EN_RESET    = 16'h6000;
  localparam logic [15:0] PULL_UP_RESET    = 16'h2000;

  // Lock sequence progress.
  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_ONE   = 2'b01,
    LK_ZERO  = 2'b10,
    LK_DONE  = 2'b11
  } lock_state_t;

  // Register request travelling together.
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Per-pin pad controls.
  typedef struct packed {
    logic oe;
    logic out;
    logic pull_en;
    logic pull_up;
    logic in_en;
  } pad_ctrl_t;

endpackage

/* File: gpio_pin_mode.sv */
`timescale 1ns/10ps
// Decodes one pin's configuration nibble into pad controls.
module gpio_pin_mode
  import gpio_pkg::*;
(
  // Pin configuration.
  input  wire logic [3:0] nibble,
  input  wire logic       out_bit,
  input  wire logic       alt_out,
  input  wire logic       pull_en,
  input  wire logic       pull_up,
  // Pad controls.
  output pad_ctrl_t       pad
);

  logic [1:0] dir;
  logic [1:0] cfg;
  logic       od;
  logic       drive;

  // Direction in the low two bits, configuration in the high two bits.
  always_comb
  begin
    dir   = nibble[1:0];
    cfg   = nibble[3:2];
    od    = cfg[0];
    drive = cfg[1] ? alt_out : out_bit;
    pad   = '0;
    pad.in_en = 1'b1;
    if (dir == 2'b00)
    begin
      pad.oe = 1'b0;
      if (cfg == 2'b00)
        pad.in_en = 1'b0;               // Analog input leaves the digital path off.
      else if (cfg == 2'b10)
      begin
        pad.pull_en = 1'b1;
        pad.pull_up = out_bit;
      end
    end
    else
    begin
      // Open drain only pulls low; push-pull drives both levels.
      pad.out = drive;
      pad.oe  = od ? ~drive : 1'b1;
      if (od)
      begin
        pad.pull_en = pull_en;
        pad.pull_up = pull_up;
      end
    end
  end

endmodule

/* File: gpio_lock_seq.sv */
`timescale 1ns/10ps
// Tracks the three-write lock key and holds the frozen pin mask.
module gpio_lock_seq
  import gpio_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Lock register write.
  input  wire logic        wr,
  input  wire logic [16:0] wdata,
  // Lock state.
  output logic             locked,
  output logic [15:0]      mask
);

  typedef struct packed {
    lock_state_t st;
    logic [15:0] key;
    logic [15:0] mask;
  } lock_regs_t;

  lock_regs_t s_reg;
  lock_regs_t s_next;

  // Any write off the 1-0-1 pattern or with another mask restarts the key.
  always_comb
  begin
    s_next = s_reg;
    if (wr && s_reg.st != LK_DONE)
    begin
      unique case (s_reg.st)
        LK_IDLE:
        begin
          if (wdata[16])
          begin
            s_next.st  = LK_ONE;
            s_next.key = wdata[15:0];
          end
        end
        LK_ONE:
          s_next.st = (!wdata[16] && wdata[15:0] == s_reg.key) ? LK_ZERO : LK_IDLE;
        LK_ZERO:
        begin
          if (wdata[16] && wdata[15:0] == s_reg.key)
          begin
            s_next.st   = LK_DONE;
            s_next.mask = s_reg.key;
          end
          else
            s_next.st = LK_IDLE;
        end
        LK_DONE: s_next.st = LK_DONE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign locked = (s_reg.st == LK_DONE);
  assign mask   = s_reg.mask;

  a_lock_sticky: assert property (@(posedge clk) disable iff (!rstn)
    locked |=> locked) else $error("lock released without reset");
  a_mask_frozen: assert property (@(posedge clk) disable iff (!rstn)
    locked |=> $stable(mask)) else $error("lock mask changed");
  a_abandon_seq: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.st == LK_ONE && wr && wdata[15:0] != s_reg.key) |=> s_reg.st == LK_IDLE)
    else $error("bad key write kept sequence");

endmodule

/* File: gpio_pad_model.sv */
`timescale 1ns/10ps
// Pin-side model: a pin follows the design's driver, else an external source, else its pull.
module gpio_pad_model
(
  // Clock.
  input  wire logic        clk,
  // Design pad controls.
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [15:0] pad_pull_en,
  input  wire logic [15:0] pad_pull_up,
  // External sources.
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  // Resolved pin levels.
  output logic [15:0]      pad_in
);
  logic [15:0] drift;

  // An undriven, unpulled pin wanders every cycle, so a stale level never passes for valid.
  initial drift = 16'h0000;
  always @(posedge clk) drift <= ~drift;

  // Driver wins over the outside world, which wins over a weak pull.
  always_comb
    for (int i = 0; i < 16; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pad_pull_en[i] ? pad_pull_up[i] : drift[i];
endmodule

/* File: gpio_pin_config_lock_bench.sv */
`timescale 1ns/10ps
module gpio_pin_config_lock_bench;
  import gpio_pkg::*;
  logic         clk;
  logic         rstn;
  reg_req_t     req;
  logic [31:0]  rdata;
  logic [15:0]  pad_in;
  logic [15:0]  pad_out;
  logic [15:0]  pad_oe;
  logic [15:0]  pad_pull_en;
  logic [15:0]  pad_pull_up;
  logic [15:0]  pad_in_en;
  logic [255:0] periph_out;
  logic [15:0]  periph_in;
  logic [15:0]  ext_en;
  logic [15:0]  ext_val;
  logic [31:0]  d;
  int           fail_count;
  int           tests_run;

  gpio_pin_config_lock uut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .pad_in_en(pad_in_en), .periph_out(periph_out),
    .periph_in(periph_in));
  gpio_pad_model pins (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // Clock at 50 MHz.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  // One-cycle write; the strobe drops at the next edge.
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Pads follow a register change one edge later; two edges leave margin.
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk("pad_oe", pad_oe, 32'h0000_0000);
    chk("pull_en", pad_pull_en, 32'h0000_6000);
    chk("pull_up", pad_pull_up, 32'h0000_2000);
    chk("in_en", pad_in_en, 32'h0000_FFFF);
    rd(OFF_CONFIG_LOW, d);
    chk("cfg_low", d, 32'h4444_4444);
    rd(OFF_CONFIG_HIGH, d);
    chk("cfg_high", d, 32'h4884_4444);
    rd(OFF_OUTPUT_DATA, d);
    chk("odata", d, 32'h0000_2000);
    rd(6'h3C, d);
    chk("unmapped", d, 32'h0000_0000);
    $display("reset test done");
  endtask

  task automatic t_input;
    @(posedge clk);
    ext_en <= 16'h9FFF;
    ext_val <= 16'hC35A;
    settle;
    rd(OFF_INPUT_DATA, d);
    chk("idata", d[15:0], 32'h0000_A35A);
    chk("periph_in", periph_in, 32'h0000_A35A);
    @(posedge clk);
    ext_val <= 16'h3CA5;
    wr(OFF_OUTPUT_DATA, 32'h0000_A5C3);
    settle;
    rd(OFF_INPUT_DATA, d);
    chk("idata", d[15:0], 32'h0000_3CA5);
    rd(OFF_OUTPUT_DATA, d);
    chk("odata", d, 32'h0000_A5C3);
    @(posedge clk);
    ext_en <= 16'h0000;
    $display("input test done");
  endtask

  // Sets pin 0: ctl is {output bit, pull enable, pull up, peripheral level};
  // exp is {oe, out, pull_en, pull_up, in_en}.
  task automatic mode_case(input logic [3:0] nib, input logic [3:0] ctl, input logic [4:0] exp);
    wr(OFF_OUTPUT_DATA, {31'h0, ctl[3]});
    periph_out <= {240'h0, (ctl[0] ? 16'h0020 : 16'hFFDF)};
    wr(OFF_OD_PULL, {15'h0, ctl[1], 15'h0, ctl[2]});
    wr(OFF_CONFIG_LOW, {28'h444_4444, nib});
    settle;
    chk("pad_oe0", pad_oe[0], exp[4]);
    if (exp[4])
      chk("pad_out0", pad_out[0], exp[3]);
    chk("pull_en0", pad_pull_en[0], exp[2]);
    if (exp[2])
      chk("pull_up0", pad_pull_up[0], exp[1]);
    chk("in_en0", pad_in_en[0], exp[0]);
  endtask

  task automatic t_modes;
    wr(OFF_ALT_LOW, 32'h0000_0005);
    mode_case(4'h0, 4'b0000, 5'b00000);
    mode_case(4'h4, 4'b1110, 5'b00001);
    mode_case(4'h8, 4'b1000, 5'b00111);
    mode_case(4'h8, 4'b0110, 5'b00101);
    mode_case(4'h1, 4'b1110, 5'b11001);
    mode_case(4'h3, 4'b0000, 5'b10001);
    mode_case(4'h5, 4'b0110, 5'b10111);
    mode_case(4'h6, 4'b1100, 5'b00101);
    mode_case(4'h5, 4'b1000, 5'b00001);
    mode_case(4'h9, 4'b0001, 5'b11001);
    mode_case(4'hA, 4'b1000, 5'b10001);
    mode_case(4'hD, 4'b0110, 5'b10111);
    mode_case(4'hE, 4'b0111, 5'b00111);
    wr(OFF_CONFIG_LOW, 32'h4444_4444);
    $display("mode test done");
  endtask

  task automatic t_lock;
    // A repeated key of 1 and then a changed mask must both abandon the sequence.
    wr(OFF_CONFIG_LOCK, 32'h0001_0001);
    wr(OFF_CONFIG_LOCK, 32'h0001_0001);
    wr(OFF_CONFIG_LOCK, 32'h0001_0001);
    wr(OFF_CONFIG_LOCK, 32'h0000_0002);
    rd(OFF_CONFIG_LOCK, d);
    chk("lock_key", d[16], 32'h0000_0000);
    wr(OFF_CONFIG_LOCK, 32'h0001_0001);
    wr(OFF_CONFIG_LOCK, 32'h0000_0001);
    wr(OFF_CONFIG_LOCK, 32'h0001_0001);
    rd(OFF_CONFIG_LOCK, d);
    chk("lock_reg", d, 32'h0001_0001);
    wr(OFF_CONFIG_LOCK, 32'h0000_0000);
    rd(OFF_CONFIG_LOCK, d);
    chk("lock_reg", d, 32'h0001_0001);
    wr(OFF_CONFIG_LOW, 32'h1111_1111);
    rd(OFF_CONFIG_LOW, d);
    chk("cfg_low", d, 32'h1111_1114);
    wr(OFF_CONFIG_HIGH, 32'h4444_4444);
    wr(OFF_OUTPUT_DATA, 32'h0000_0055);
    rd(OFF_CONFIG_HIGH, d);
    chk("cfg_high", d, 32'h4444_4444);
    settle;
    chk("pad_oe", pad_oe[1:0], 32'h0000_0002);
    $display("lock test done");
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Guard against a hang; running out counts as a mismatch.
  initial
  begin
    #1000000;
    fail_count++;
    end_of_test;
  end

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rstn = 1'b0;
    req = '{addr: 6'h00, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b0};
    periph_out = '0;
    ext_en = 16'h0000;
    ext_val = 16'h0000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset;
    t_input;
    t_modes;
    t_lock;
    end_of_test;
  end
endmodule
